// *** mframe_gate.sv ***
// multiframe counter with external M-bit sync, channel gating and bus-to-line FIFO
// assumes frameStart pulses once per S/T frame at the F-bit and the line framer shares sys_clk
//
// Local design decisions: the register addresses and the APB register port.
module mframe_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign push = ce && inValid && (count_q != AW'(0) + (AW+1)'(DEPTH));
    assign pop = ce && outReady && (count_q != '0);
    assign inReady = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign level = count_q;

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
            end
            if (pop)
            begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Contract
// R1 - select bit turns pin four into M-bit
// R2 - pin direction follows operating mode only
// R3 - software sets multiframe enable in network modes
// R4 - sample sync input at each F-bit start
// R5 - input one forces frame 20, bits zero
// R6 - input zero: count frames 1..20, wrap
// R7 - held input keeps counter reset, bits zero
// R8 - one-frame zero gives frame 1, S11
// R9 - terminal modes drive received M-bit out
// R10 - outside logic samples pin at strobe fall
// R11 - terminal: line-to-bus transparent when active, else ones
// R12 - terminal: bus-to-line needs request or enable
// R13 - stop/go mode times D by priority
// R14 - line-card-T frame relation is flexible
// R15 - network modes: B1 B2 D gated likewise
// R16 - intelligent NT lets handler block D
// R17 - 20-frame multiframe, FA/M/S pattern
// R18 - select clear leaves pin as GPIO
module mframe_gate #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frameStart,
    input wire logic activatedState,
    input wire logic rxMultiframing,
    input wire mframe_pkg::chan_t lineRxData,
    input wire logic lineRxValid,
    output mframe_pkg::chan_t busTxData,
    output logic busTxValid,
    input wire mframe_pkg::chan_t busRxData,
    input wire logic busRxValid,
    output logic busRxReady,
    output mframe_pkg::chan_t lineTxData,
    output logic lineTxValid,
    output mframe_pkg::mfbits_t lineTxBits,
    input wire logic stopGoPermit,
    input wire logic dchannelBlock,
    input wire logic auxPinIn,
    output logic auxPinOut,
    output logic auxPinOe,
    output logic [4:0] frameNumber
);
    logic [31:0] ctrl_q;
    logic [3:0] sData_q;
    logic actRequest_q;
    logic [2:0] auxSync_q;
    logic auxLevel_q;
    logic mbitSample_q;
    logic rxM_q;
    logic [4:0] frame_q;
    logic [4:0] frame_d;
    logic [$clog2(FIFO_DEPTH):0] fifoLevel;
    logic fifoInReady;
    mframe_pkg::chan_t fifoOut;
    logic fifoOutValid;
    logic fifoPop;
    mframe_pkg::opmode_t mode;
    logic pinSel;
    logic mfEnable;
    logic smDisable;
    logic tdDisable;
    logic stopGo;
    logic netMode;
    logic rxPass;
    logic txPass;
    logic apbAccess;
    logic mapped;
    logic [31:0] readWord;

    assign mode = mframe_pkg::opmode_t'(ctrl_q[mframe_pkg::CTRL_MODE_LSB +: 3]);
    assign pinSel = ctrl_q[mframe_pkg::CTRL_PIN_SEL];
    assign mfEnable = ctrl_q[mframe_pkg::CTRL_MF_ENABLE];
    assign smDisable = ctrl_q[mframe_pkg::CTRL_SM_DISABLE];
    assign tdDisable = ctrl_q[mframe_pkg::CTRL_TD_DISABLE];
    assign stopGo = ctrl_q[mframe_pkg::CTRL_STOP_GO];
    // network side: the M-bit pin is an input, otherwise an output (see R2)
    assign netMode = (mode == mframe_pkg::MODE_LINE_CARD_S) || (mode == mframe_pkg::MODE_NETWORK_TERM)
        || (mode == mframe_pkg::MODE_INTELLIGENT_NT);

    // apb slave: one wait state so prdata and pready come from flops
    assign apbAccess = ce && psel && penable && !pready;
    assign mapped = (paddr == mframe_pkg::ADDR_CTRL) || (paddr == mframe_pkg::ADDR_CMD)
        || (paddr == mframe_pkg::ADDR_STATUS) || (paddr == mframe_pkg::ADDR_SDATA);

    always_comb
    begin
        readWord = '0;
        case (paddr)
            mframe_pkg::ADDR_CTRL: readWord = ctrl_q;
            mframe_pkg::ADDR_CMD: readWord = {31'h0000_0000, actRequest_q};
            mframe_pkg::ADDR_STATUS:
            begin
                readWord[mframe_pkg::STAT_FRAME_LSB +: 5] = frame_q;
                readWord[mframe_pkg::STAT_ACTIVATED] = activatedState;
                readWord[mframe_pkg::STAT_MULTIFRAME_SYNC_PIN] = mbitSample_q;
                readWord[mframe_pkg::STAT_AUX_IN] = auxLevel_q;
                readWord[mframe_pkg::STAT_LEVEL_LSB +: 4] = 4'(fifoLevel);
                readWord[mframe_pkg::STAT_ACT_REQ] = actRequest_q;
            end
            mframe_pkg::ADDR_SDATA: readWord = {28'h000_0000, sData_q};
            default: readWord = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else if (ce)
        begin
            pready <= apbAccess;
            pslverr <= apbAccess && !mapped;
            if (apbAccess && !pwrite)
            begin
                prdata <= readWord;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= mframe_pkg::CTRL_RESET;
            sData_q <= '0;
        end
        else if (apbAccess && pwrite)
        begin
            if (paddr == mframe_pkg::ADDR_CTRL)
            begin
                ctrl_q <= pwdata;
            end
            if (paddr == mframe_pkg::ADDR_SDATA)
            begin
                sData_q <= pwdata[3:0];
            end
        end
    end

    // activation request commands latch until a deactivate command
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            actRequest_q <= 1'b0;
        end
        else if (apbAccess && pwrite && paddr == mframe_pkg::ADDR_CMD)
        begin
            if (pwdata[3:0] == mframe_pkg::CMD_AR_PRIO_HIGH || pwdata[3:0] == mframe_pkg::CMD_AR_PRIO_LOW
                || pwdata[3:0] == mframe_pkg::CMD_AR_LOOP)
            begin
                actRequest_q <= 1'b1; // see R12
            end
            else if (pwdata[3:0] == mframe_pkg::CMD_DEACTIVATE)
            begin
                actRequest_q <= 1'b0;
            end
        end
    end

    // pin synchroniser: the level changes only once the second and third stages agree
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            auxSync_q <= '0;
            auxLevel_q <= 1'b0;
        end
        else if (ce)
        begin
            auxSync_q <= {auxSync_q[1:0], auxPinIn};
            if (auxSync_q[1] == auxSync_q[2])
            begin
                auxLevel_q <= auxSync_q[2];
            end
        end
    end

    // multiframe counter; frame 20 doubles as the reset frame since its bits are all zero
    always_comb
    begin
        frame_d = frame_q;
        if (netMode && !mfEnable)
        begin
            frame_d = mframe_pkg::FRAME_LAST; // see R3
        end
        else if (netMode && pinSel && auxLevel_q)
        begin
            frame_d = mframe_pkg::FRAME_LAST; // see R5, R7
        end
        else if (frame_q == mframe_pkg::FRAME_LAST)
        begin
            frame_d = mframe_pkg::FRAME_FIRST; // see R6, R8
        end
        else
        begin
            frame_d = frame_q + 5'h01; // see R6, R17
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_q <= mframe_pkg::FRAME_LAST;
            mbitSample_q <= 1'b0;
            lineTxBits <= '0;
        end
        else if (ce && frameStart)
        begin
            frame_q <= frame_d; // see R4
            mbitSample_q <= auxLevel_q && pinSel; // see R18
            lineTxBits.auxFraming <= (frame_d == mframe_pkg::FRAME_FIRST) || (frame_d == mframe_pkg::FRAME_AUX_2)
                || (frame_d == mframe_pkg::FRAME_AUX_3) || (frame_d == mframe_pkg::FRAME_AUX_4); // see R17
            lineTxBits.multiframing <= (frame_d == mframe_pkg::FRAME_FIRST); // see R8, R17
            case (frame_d)
                mframe_pkg::FRAME_FIRST: lineTxBits.sBit <= sData_q[0];
                mframe_pkg::FRAME_AUX_2: lineTxBits.sBit <= sData_q[1];
                mframe_pkg::FRAME_AUX_3: lineTxBits.sBit <= sData_q[2];
                mframe_pkg::FRAME_AUX_4: lineTxBits.sBit <= sData_q[3];
                default: lineTxBits.sBit <= 1'b0; // see R5
            endcase
        end
    end

    assign frameNumber = frame_q;

    // received M-bit, updated at the F-bit so it stays stable across a strobe edge
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxM_q <= 1'b0;
        end
        else if (ce && frameStart)
        begin
            rxM_q <= rxMultiframing; // see R10
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            auxPinOut <= 1'b0;
            auxPinOe <= 1'b0;
        end
        else if (ce)
        begin
            if (pinSel)
            begin
                auxPinOe <= !netMode; // see R1, R2
                auxPinOut <= netMode ? 1'b0 : rxM_q; // see R9
            end
            else
            begin
                auxPinOe <= ctrl_q[mframe_pkg::CTRL_GPIO_OE]; // see R18
                auxPinOut <= ctrl_q[mframe_pkg::CTRL_GPIO_OUT];
            end
        end
    end

    // line to bus gating
    assign rxPass = activatedState
        || (smDisable && ctrl_q[mframe_pkg::CTRL_TRANSMIT_INFO_SELECT_LSB +: 3] == mframe_pkg::TRANSMIT_INFO_SELECT_TRANSPARENT);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busTxData <= mframe_pkg::CHAN_IDLE;
            busTxValid <= 1'b0;
        end
        else if (ce)
        begin
            busTxValid <= lineRxValid;
            if (lineRxValid)
            begin
                busTxData <= mframe_pkg::CHAN_IDLE;
                if (rxPass)
                begin
                    busTxData.b1 <= lineRxData.b1; // see R11, R15
                    busTxData.b2 <= lineRxData.b2;
                    busTxData.d <= lineRxData.d;
                    if (!netMode)
                    begin
                        busTxData.e <= lineRxData.e; // see R11
                    end
                end
            end
        end
    end

    // bus to line: the FIFO decouples the bus frame from the line frame (see R14)
    assign busRxReady = fifoInReady;
    assign fifoPop = frameStart;

    mframe_fifo #(
        .WIDTH(mframe_pkg::CHAN_W),
        .DEPTH(FIFO_DEPTH)
    ) dataFifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .inData(busRxData),
        .inValid(busRxValid),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .level(fifoLevel)
    );

    // terminal side also needs an activation request, or an enabled transmitter without the state machine
    assign txPass = netMode ? activatedState : (smDisable ? !tdDisable : actRequest_q);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lineTxData <= mframe_pkg::CHAN_IDLE;
            lineTxValid <= 1'b0;
        end
        else if (ce)
        begin
            lineTxValid <= frameStart && fifoOutValid;
            if (frameStart)
            begin
                lineTxData <= mframe_pkg::CHAN_IDLE;
                if (fifoOutValid && txPass)
                begin
                    lineTxData.b1 <= fifoOut.b1; // see R12
                    lineTxData.b2 <= fifoOut.b2;
                    if (!(stopGo && !netMode && !stopGoPermit)
                        && !(mode == mframe_pkg::MODE_INTELLIGENT_NT && dchannelBlock))
                    begin
                        lineTxData.d <= fifoOut.d; // see R13, R16
                    end
                end
            end
        end
    end
endmodule

// *** mframe_pkg.sv ***
// shared constants, register map and carrier types for the multiframe sync and data gate
// assumes a 32-bit APB master and a line framer running on the same system clock
package mframe_pkg;

    typedef enum logic [2:0] {
        MODE_TERMINAL = 3'h0,
        MODE_LINE_CARD_T = 3'h1,
        MODE_LINE_CARD_S = 3'h3,
        MODE_NETWORK_TERM = 3'h2,
        MODE_INTELLIGENT_NT = 3'h6
    } opmode_t;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_SDATA = 8'h0C;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PIN_SEL = 3;
    localparam int CTRL_MF_ENABLE = 4;
    localparam int CTRL_SM_DISABLE = 5;
    localparam int CTRL_TRANSMIT_INFO_SELECT_LSB = 6;
    localparam int CTRL_TD_DISABLE = 9;
    localparam int CTRL_STOP_GO = 10;
    localparam int CTRL_GPIO_OUT = 11;
    localparam int CTRL_GPIO_OE = 12;

    // status register fields
    localparam int STAT_FRAME_LSB = 0;
    localparam int STAT_ACTIVATED = 5;
    localparam int STAT_MULTIFRAME_SYNC_PIN = 6;
    localparam int STAT_AUX_IN = 7;
    localparam int STAT_LEVEL_LSB = 8;
    localparam int STAT_ACT_REQ = 12;

    // activation commands written to the command register
    localparam logic [3:0] CMD_DEACTIVATE = 4'h0;
    localparam logic [3:0] CMD_AR_PRIO_HIGH = 4'h8;
    localparam logic [3:0] CMD_AR_PRIO_LOW = 4'h9;
    localparam logic [3:0] CMD_AR_LOOP = 4'hA;

    localparam logic [2:0] TRANSMIT_INFO_SELECT_TRANSPARENT = 3'h3;
    localparam logic [4:0] FRAME_FIRST = 5'h01;
    localparam logic [4:0] FRAME_LAST = 5'h14;
    localparam logic [4:0] FRAME_AUX_2 = 5'h06;
    localparam logic [4:0] FRAME_AUX_3 = 5'h0B;
    localparam logic [4:0] FRAME_AUX_4 = 5'h10;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [1:0] d;
        logic [1:0] e;
    } chan_t;

    localparam int CHAN_W = $bits(chan_t);
    localparam chan_t CHAN_IDLE = '{b1: 8'hFF, b2: 8'hFF, d: 2'h3, e: 2'h3};

    typedef struct packed {
        logic auxFraming;
        logic multiframing;
        logic sBit;
    } mfbits_t;

endpackage

// *** mframe_gate_monitor.sv ***
// checker on the multiframe gate ports
// assumes one clock domain and frameStart pulses from the line framer
module mframe_gate_monitor (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic frameStart,
    input wire logic lineRxValid,
    input wire logic busTxValid,
    input wire logic lineTxValid,
    input wire mframe_pkg::mfbits_t lineTxBits,
    input wire logic [4:0] frameNumber
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_taken;
        psel && penable && ce && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_answer;
        s_taken |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("apb answer wrong");
    property p_frameHold;
        !$past(frameStart) |-> $stable(frameNumber);
    endproperty
    a_frameHold: assert property (p_frameHold) else $error("frame moved mid frame");
    property p_step;
        frameStart && ce && frameNumber inside {[5'h01:5'h13]}
            |=> frameNumber == $past(frameNumber) + 5'h01 || frameNumber == 5'h14;
    endproperty
    a_step: assert property (p_step) else $error("frame step wrong");
    property p_wrap;
        frameStart && ce && frameNumber == 5'h14 |=> frameNumber inside {5'h01, 5'h14};
    endproperty
    a_wrap: assert property (p_wrap) else $error("frame wrap wrong");
    property p_faBit;
        $past(frameStart) |-> lineTxBits.auxFraming == (frameNumber inside {5'h01, 5'h06, 5'h0B, 5'h10})
            && lineTxBits.multiframing == (frameNumber == 5'h01);
    endproperty
    a_faBit: assert property (p_faBit) else $error("framing bits wrong");
    property p_frame20;
        frameNumber == 5'h14 |-> lineTxBits == 3'h0;
    endproperty
    a_frame20: assert property (p_frame20) else $error("frame 20 bits set");
    property p_busTx;
        busTxValid |-> $past(lineRxValid);
    endproperty
    a_busTx: assert property (p_busTx) else $error("bus word uncaused");
    property p_lineTx;
        lineTxValid |-> $past(frameStart);
    endproperty
    a_lineTx: assert property (p_lineTx) else $error("line word off frame");
endmodule

bind mframe_gate mframe_gate_monitor i_mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
    .frameStart(frameStart), .lineRxValid(lineRxValid), .busTxValid(busTxValid),
    .lineTxValid(lineTxValid), .lineTxBits(lineTxBits), .frameNumber(frameNumber)
);

// *** mframe_line_model.sv ***
// line framer stand-in: paces frames and delivers received channel words
// assumes the bench clock and reset; a frame is shortened to FRAME_CYC cycles
module mframe_line_model #(
    parameter int FRAME_CYC = 40
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    output logic frameStart,
    output logic rxMultiframing,
    output mframe_pkg::chan_t lineRxData,
    output logic lineRxValid
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;
    int frm;
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cyc <= 0;
            frm <= 0;
            frameStart <= 1'b0;
            rxMultiframing <= 1'b0;
            lineRxValid <= 1'b0;
            lineRxData <= '0;
        end
        else
        begin
            cyc <= (cyc == FRAME_CYC - 1) ? 0 : cyc + 1;
            frameStart <= cyc == FRAME_CYC - 1;
            lineRxValid <= cyc == FRAME_CYC / 2;
            // scrambled outside the valid cycle so stale data is never trusted
            lineRxData <= (cyc == FRAME_CYC / 2) ? 20'($urandom) : ~lineRxData;
            if (cyc == FRAME_CYC - 1)
            begin
                frm <= (frm == 19) ? 0 : frm + 1;
                rxMultiframing <= frm == 19;
            end
        end
    end
endmodule

// *** tb.sv ***
// self-checking bench for the multiframe gate
// assumes the line model paces 40-cycle frames on the 125 MHz clock
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, frameStart, rxMultiframing;
    logic activatedState, lineRxValid, busTxValid, busRxValid, busRxReady, lineTxValid;
    logic stopGoPermit, dchannelBlock, auxPinIn, auxPinOut, auxPinOe, reqFlag, mLatch;
    logic chkBus = 0, chkLine = 0, chkF = 0, room;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, c, ctrl, sdata, expF;
    logic [4:0] frameNumber;
    logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h0};
    logic [3:0] cmds [6] = '{4'h8, 4'h9, 4'hA, 4'h0, 4'h8, 4'h0};
    mframe_pkg::chan_t lineRxData, busTxData, busRxData, lineTxData, expBus, expLine;
    mframe_pkg::chan_t fifoQ[$];
    mframe_pkg::mfbits_t lineTxBits;
    int error_cnt, compares;
    int frm = 20;
    mframe_gate i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frameStart(frameStart), .activatedState(activatedState), .rxMultiframing(rxMultiframing),
        .lineRxData(lineRxData), .lineRxValid(lineRxValid), .busTxData(busTxData), .busTxValid(busTxValid),
        .busRxData(busRxData), .busRxValid(busRxValid), .busRxReady(busRxReady), .lineTxData(lineTxData),
        .lineTxValid(lineTxValid), .lineTxBits(lineTxBits), .stopGoPermit(stopGoPermit),
        .dchannelBlock(dchannelBlock), .auxPinIn(auxPinIn), .auxPinOut(auxPinOut), .auxPinOe(auxPinOe),
        .frameNumber(frameNumber)
    );
    mframe_line_model i_line (
        .sys_clk(sys_clk), .rst_b(rst_b), .frameStart(frameStart), .rxMultiframing(rxMultiframing),
        .lineRxData(lineRxData), .lineRxValid(lineRxValid)
    );
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        chkWord({31'h0, got}, {31'h0, exp});
    endtask
    task automatic chkChan(input mframe_pkg::chan_t got, input mframe_pkg::chan_t exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t chan %h exp %h", $time, got, exp);
        end
    endtask
    function automatic mframe_pkg::chan_t gateRx(mframe_pkg::chan_t d);
        if (!(activatedState || (ctrl[5] && ctrl[8:6] == 3'h3)))
            d = mframe_pkg::CHAN_IDLE;
        if (ctrl[2:0] > 3'h1)
            d.e = 2'h3;
        return d;
    endfunction
    function automatic mframe_pkg::chan_t gateTx(mframe_pkg::chan_t d);
        if (!((ctrl[2:0] > 3'h1) ? activatedState : (ctrl[5] ? !ctrl[9] : reqFlag)))
            return mframe_pkg::CHAN_IDLE;
        if ((ctrl[10] && ctrl[2:0] < 3'h2 && !stopGoPermit) || (ctrl[2:0] == 3'h6 && dchannelBlock))
            d.d = 2'h3;
        // echo bits are never sent toward the line, they idle high
        d.e = 2'h3;
        return d;
    endfunction
    function automatic logic [31:0] expBits(int f);
        logic fa;
        fa = (f - 1) % 5 == 0;
        return {29'h0, fa, f == 1, fa && sdata[(f - 1) / 5]};
    endfunction
    // model of the gate, compared at every registered result
    always @(posedge sys_clk)
    begin
        if (rst_b)
        begin
            chkBit(busTxValid, chkBus);
            if (chkBus) chkChan(busTxData, expBus);
            chkBit(lineTxValid, chkLine);
            if (chkF) chkChan(lineTxData, expLine);
            if (chkF) chkWord(32'(frameNumber), frm);
            if (chkF) chkWord(32'(lineTxBits), expF);
            room = fifoQ.size() < 8;
            chkBit(busRxReady, room);
            chkBus = lineRxValid;
            expBus = gateRx(lineRxData);
            chkF = frameStart;
            chkLine = frameStart && fifoQ.size() > 0;
            if (frameStart)
            begin
                expLine = chkLine ? gateTx(fifoQ.pop_front()) : mframe_pkg::CHAN_IDLE;
                if (ctrl[2:0] > 3'h1 && (!ctrl[4] || (ctrl[3] && auxPinIn)))
                    frm = 20;
                else
                    frm = (frm == 20) ? 1 : frm + 1;
                // taken now: the stimulus may rewrite sdata on the edge that compares
                expF = expBits(frm);
                mLatch = rxMultiframing;
            end
            if (busRxValid && room)
                fifoQ.push_back(busRxData);
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chkBit(pready, 1'b1);
        chkBit(pslverr, err);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic push();
        int n;
        busRxValid <= 1'b1;
        busRxData <= 20'($urandom);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (busRxReady !== 1'b1 && n < 100);
        chkBit(busRxReady, 1'b1);
    endtask
    task automatic frame();
        do @(posedge sys_clk); while (frameStart !== 1'b1);
        @(posedge sys_clk);
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        {psel, penable, pwrite, busRxValid, auxPinIn, activatedState, stopGoPermit, dchannelBlock} = '0;
        paddr = '0;
        pwdata = '0;
        busRxData = '0;
        ctrl = '0;
        sdata = '0;
        reqFlag = 1'b0;
        ce = 1'b1;
        rst_b = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        void'($urandom(32'h2EE7414A));
        apb(0, mframe_pkg::ADDR_CTRL, 0, 0);
        chkWord(rd, mframe_pkg::CTRL_RESET);
        apb(0, 8'h10, 0, 1);
        for (int p = 0; p < 6; p++)
        begin
            frame();
            c = $urandom;
            // pin select off only in the last pass, so the pin falls back to general use
            ctrl = (c & 32'h1FE0) | 32'h10 | {28'h0, p < 5, modes[p]};
            if (c[13])
                ctrl[8:6] = 3'h3;
            sdata = {28'h0, c[17:14]};
            apb(1, mframe_pkg::ADDR_CTRL, ctrl, 0);
            apb(0, mframe_pkg::ADDR_CTRL, 0, 0);
            chkWord(rd, ctrl);
            apb(1, mframe_pkg::ADDR_SDATA, sdata, 0);
            apb(1, mframe_pkg::ADDR_CMD, {28'h0, cmds[p]}, 0);
            reqFlag = cmds[p] != 4'h0;
            apb(0, mframe_pkg::ADDR_CMD, 0, 0);
            chkWord(rd & 32'h1, {31'h0, reqFlag});
            apb(0, mframe_pkg::ADDR_STATUS, 0, 0);
            chkWord(rd & 32'h1F, frm);
            for (int f = 0; f < 26; f++)
            begin
                frame();
                auxPinIn <= f < 3 || f == 4;
                activatedState <= 1'($urandom);
                stopGoPermit <= 1'($urandom);
                dchannelBlock <= 1'($urandom);
                repeat (4) @(posedge sys_clk);
                chkBit(auxPinOe, ctrl[3] ? ctrl[2:0] < 3'h2 : ctrl[12]);
                if (!ctrl[3] || ctrl[2:0] < 3'h2) chkBit(auxPinOut, ctrl[3] ? mLatch : ctrl[11]);
                // more pushes than pops per frame, so the buffer fills and refuses
                if (f > 5 && f < 16)
                begin
                    repeat (3) push();
                    busRxValid <= 1'b0;
                end
            end
        end
        tally_and_finish();
    end
endmodule
